// ===== src/psr_pkg.sv
// Purpose: constants and types for the parameter store/restore block
// Assumes: object-dictionary style access, index plus subindex, 32-bit data
// Notes: the storage medium is outside; this block only sequences requests
package psr_pkg;
    localparam logic [15:0] IDX_STORE = 16'h1010;
    localparam logic [15:0] IDX_DISCARD = 16'h1011;
    localparam logic [15:0] IDX_VERIFY = 16'h1020;
    localparam logic [15:0] IDX_REBOOT = 16'h2800;
    localparam logic [15:0] IDX_USER_PROG = 16'h2300;
    localparam logic [31:0] KEY_SAVE = 32'h65766173;
    localparam logic [31:0] KEY_LOAD = 32'h64616F6C;
    localparam logic [31:0] KEY_BOOT = 32'h746F6F62;
    localparam logic [31:0] STORE_DONE_VAL = 32'h00000001;
    localparam logic [31:0] VERIFY_RST_VAL = 32'h00000000;
    localparam logic [31:0] USER_PROG_RST_VAL = 32'h00000001;
    localparam int USER_PROG_RUN_BIT = 0;
    localparam logic [7:0] SUB_ALL = 8'h01;
    localparam logic [7:0] SUB_COMM = 8'h02;
    localparam logic [7:0] SUB_APP = 8'h03;
    localparam logic [7:0] SUB_CUST = 8'h04;
    localparam logic [7:0] SUB_DRIVE = 8'h05;
    localparam logic [7:0] SUB_TUNE = 8'h06;
    localparam logic [7:0] SUB_MODBUS = 8'h0B;
    localparam logic [7:0] SUB_BOOT = 8'h01;
    localparam logic [7:0] SUB_VER_DATE = 8'h01;
    localparam logic [7:0] SUB_VER_TIME = 8'h02;
    localparam int CAT_W = 7;
    // category mask bits
    localparam int CAT_COMM = 0;
    localparam int CAT_APP = 1;
    localparam int CAT_CUST = 2;
    localparam int CAT_DRIVE = 3;
    localparam int CAT_TUNE = 4;
    localparam int CAT_MODBUS = 5;
    localparam int NUM_SUB = 7;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAVE = 2'b01,
        ST_DISCARD = 2'b10
    } psr_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
        logic savable;
    } psr_req_t;

    typedef struct packed {
        psr_state_t state;
        logic [2:0] slot;
        logic [NUM_SUB*32-1:0] store_val;
        logic [NUM_SUB*32-1:0] discard_val;
        logic [31:0] ver_date;
        logic [31:0] ver_time;
        logic [31:0] user_prog;
        logic [31:0] rdata;
        logic rvalid;
        logic nv_save;
        logic nv_discard;
        logic [CAT_W-1:0] nv_cats;
        logic restart;
        logic prog_start;
        logic boot_seen;
    } psr_state_reg_t;
endpackage

// ===== src/psr_store_restore.sv
// Purpose: keyed save/discard/restart command logic of the parameter dictionary
// Assumes: one dictionary access per cycle; storage engine acks with nv_done_in
// Notes: live values are held elsewhere; this block starts storage jobs and raises the restart, reload and autostart pulses
`timescale 1ns/1ps

// Notes on behaviour
// - save key written to a store subindex starts saving that category
// - on completion the store subindex is overwritten with one
// - store subindices 01 all, 02..06 single categories, 0B modbus settings
// - discard key written to a discard subindex marks saved data for deletion
// - discard subindex 01 covers all categories except tuning
// - discard leaves live values alone; takes effect only after restart
// - boot key at reboot subindex 01 requests a device restart
// - marker entries accept date and time, saved with store subindex 01
// - any savable write clears markers, except store 01 and marker writes
// - loaded user program autostarts after restart; reset sets control bit 0 to one, so a cleared bit never stops it
// - saved values reload at each power-on or reset
// - only whole categories persist; uncategorised values never do
module psr_store_restore
    import psr_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire psr_req_t req_in,
    input wire logic nv_done_in,
    input wire logic prog_loaded_in,
    output logic [31:0] rdata_out,
    output logic rvalid_out,
    output logic nv_save_out,
    output logic nv_discard_out,
    output logic [CAT_W-1:0] nv_cats_out,
    output logic nv_reload_out,
    output logic restart_out,
    output logic prog_start_out,
    output logic busy_out
);
    psr_state_reg_t st_reg;
    psr_state_reg_t st_next;

    // slot number for a store/discard subindex, 7 means not mapped
    function automatic logic [2:0] sub_slot(input logic [7:0] sub);
        unique case (sub)
            SUB_ALL: sub_slot = 3'd0;
            SUB_COMM: sub_slot = 3'd1;
            SUB_APP: sub_slot = 3'd2;
            SUB_CUST: sub_slot = 3'd3;
            SUB_DRIVE: sub_slot = 3'd4;
            SUB_TUNE: sub_slot = 3'd5;
            SUB_MODBUS: sub_slot = 3'd6;
            default: sub_slot = 3'd7;
        endcase
    endfunction

    // category mask; the whole-set save includes tuning, the whole-set discard not
    function automatic logic [CAT_W-1:0] slot_cats(input logic [2:0] slot,
                                                   input logic is_discard);
        logic [CAT_W-1:0] m;
        m = '0;
        unique case (slot)
            3'd0:
            begin
                m = {1'b1, {(CAT_W-1){1'b1}}};
                if (is_discard)
                begin
                    m[CAT_TUNE] = 1'b0;
                end
            end
            3'd1: m[CAT_COMM] = 1'b1;
            3'd2: m[CAT_APP] = 1'b1;
            3'd3: m[CAT_CUST] = 1'b1;
            3'd4: m[CAT_DRIVE] = 1'b1;
            3'd5: m[CAT_TUNE] = 1'b1;
            3'd6: m[CAT_MODBUS] = 1'b1;
            default: m = '0;
        endcase
        slot_cats = m;
    endfunction

    always_comb
    begin
        logic [2:0] slot;
        logic is_store;
        logic is_disc;
        logic is_ver;
        slot = sub_slot(req_in.sub);
        is_store = req_in.wr && (req_in.index == IDX_STORE) && (slot != 3'd7);
        is_disc = req_in.wr && (req_in.index == IDX_DISCARD) && (slot != 3'd7);
        is_ver = req_in.wr && (req_in.index == IDX_VERIFY);
        st_next = st_reg;
        st_next.nv_save = 1'b0;
        st_next.nv_discard = 1'b0;
        st_next.restart = 1'b0;
        st_next.prog_start = 1'b0;
        st_next.rvalid = req_in.rd;
        st_next.rdata = '0;

        // reads
        if (req_in.rd)
        begin
            if (req_in.index == IDX_STORE && sub_slot(req_in.sub) != 3'd7)
            begin
                st_next.rdata = st_reg.store_val[sub_slot(req_in.sub)*32 +: 32];
            end
            else if (req_in.index == IDX_DISCARD && sub_slot(req_in.sub) != 3'd7)
            begin
                st_next.rdata = st_reg.discard_val[sub_slot(req_in.sub)*32 +: 32];
            end
            else if (req_in.index == IDX_VERIFY && req_in.sub == SUB_VER_DATE)
            begin
                st_next.rdata = st_reg.ver_date;
            end
            else if (req_in.index == IDX_VERIFY && req_in.sub == SUB_VER_TIME)
            begin
                st_next.rdata = st_reg.ver_time;
            end
            else if (req_in.index == IDX_USER_PROG)
            begin
                st_next.rdata = st_reg.user_prog;
            end
        end

        // marker clear on savable writes; store 01 and the marker itself excluded
        if (req_in.wr && !is_ver && (req_in.savable || (req_in.index == IDX_STORE))
            && !(req_in.index == IDX_STORE && req_in.sub == SUB_ALL))
        begin
            st_next.ver_date = VERIFY_RST_VAL;
            st_next.ver_time = VERIFY_RST_VAL;
        end
        if (is_ver && req_in.sub == SUB_VER_DATE)
        begin
            st_next.ver_date = req_in.wdata;
        end
        if (is_ver && req_in.sub == SUB_VER_TIME)
        begin
            st_next.ver_time = req_in.wdata;
        end
        if (req_in.wr && req_in.index == IDX_USER_PROG)
        begin
            st_next.user_prog = req_in.wdata;
        end

        // boot key requests a restart, at any time
        if (req_in.wr && req_in.index == IDX_REBOOT && req_in.sub == SUB_BOOT
            && req_in.wdata == KEY_BOOT)
        begin
            st_next.restart = 1'b1;
        end

        unique case (st_reg.state)
            ST_IDLE:
            begin
                // commands taken only when idle; one job at a time
                if (is_store)
                begin
                    st_next.store_val[slot*32 +: 32] = req_in.wdata;
                    if (req_in.wdata == KEY_SAVE)
                    begin
                        st_next.state = ST_SAVE;
                        st_next.slot = slot;
                        st_next.nv_save = 1'b1;
                        st_next.nv_cats = slot_cats(slot, 1'b0);
                    end
                end
                else if (is_disc)
                begin
                    st_next.discard_val[slot*32 +: 32] = req_in.wdata;
                    if (req_in.wdata == KEY_LOAD)
                    begin
                        // only the saved image is touched; live values stay
                        st_next.state = ST_DISCARD;
                        st_next.slot = slot;
                        st_next.nv_discard = 1'b1;
                        st_next.nv_cats = slot_cats(slot, 1'b1);
                    end
                end
            end
            ST_SAVE:
            begin
                if (nv_done_in)
                begin
                    st_next.store_val[st_reg.slot*32 +: 32] = STORE_DONE_VAL;
                    st_next.state = ST_IDLE;
                end
            end
            ST_DISCARD:
            begin
                if (nv_done_in)
                begin
                    st_next.discard_val[st_reg.slot*32 +: 32] = STORE_DONE_VAL;
                    st_next.state = ST_IDLE;
                end
            end
            default: st_next.state = ST_IDLE;
        endcase

        // autostart one cycle after reset release
        if (!st_reg.boot_seen)
        begin
            st_next.boot_seen = 1'b1;
            st_next.prog_start = prog_loaded_in && st_reg.user_prog[USER_PROG_RUN_BIT];
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            st_reg <= '0;
            st_reg.state <= ST_IDLE;
            st_reg.user_prog <= USER_PROG_RST_VAL;
            st_reg.store_val <= {NUM_SUB{STORE_DONE_VAL}};
            st_reg.discard_val <= {NUM_SUB{STORE_DONE_VAL}};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // reload pulse right after reset; storage engine copies saved image to live
    logic reload_reg;
    // busy kept in its own flop so the port is not a decode of the state code
    logic busy_reg;
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            reload_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else
        begin
            reload_reg <= !st_reg.boot_seen;
            busy_reg <= (st_next.state != ST_IDLE);
        end
    end

    assign rdata_out = st_reg.rdata;
    assign rvalid_out = st_reg.rvalid;
    assign nv_save_out = st_reg.nv_save;
    assign nv_discard_out = st_reg.nv_discard;
    assign nv_cats_out = st_reg.nv_cats;
    assign nv_reload_out = reload_reg;
    assign restart_out = st_reg.restart;
    assign prog_start_out = st_reg.prog_start;
    assign busy_out = busy_reg;
endmodule

// ===== testbench/psr_store_restore_sva.sv
// Purpose: port assertions for the store/restore command block
// Assumes: one clock, sync reset high
// Notes: job starts only checked while idle
`timescale 1ns/1ps
module psr_store_restore_sva
    import psr_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire psr_req_t req_in,
    input wire logic nv_done_in,
    input wire logic prog_loaded_in,
    input wire logic [31:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic nv_save_out,
    input wire logic nv_discard_out,
    input wire logic [CAT_W-1:0] nv_cats_out,
    input wire logic nv_reload_out,
    input wire logic restart_out,
    input wire logic prog_start_out,
    input wire logic busy_out
);
    logic st_wr;
    logic ds_wr;
    assign st_wr = req_in.wr && req_in.index == IDX_STORE;
    assign ds_wr = req_in.wr && req_in.index == IDX_DISCARD;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    chk_save_start: assert property (
        st_wr && req_in.sub == SUB_COMM && req_in.wdata == KEY_SAVE && !busy_out
        |=> nv_save_out && nv_cats_out == 7'h01 && busy_out) else $error("save start wrong");
    chk_save_busy: assert property (nv_save_out |-> busy_out && nv_cats_out != 7'h00)
        else $error("save without busy or category");
    chk_done_idle: assert property (busy_out && nv_done_in |=> !busy_out)
        else $error("busy after done");
    chk_nokey_quiet: assert property (
        (st_wr && req_in.wdata != KEY_SAVE) || (ds_wr && req_in.wdata != KEY_LOAD)
        |=> !nv_save_out && !nv_discard_out) else $error("job started without key");
    chk_discard_all: assert property (
        ds_wr && req_in.sub == SUB_ALL && req_in.wdata == KEY_LOAD && !busy_out
        |=> nv_discard_out && !nv_cats_out[CAT_TUNE] && !nv_save_out)
        else $error("discard all wrong");
    chk_boot_key: assert property (
        req_in.wr && req_in.index == IDX_REBOOT && req_in.sub == SUB_BOOT
        && req_in.wdata == KEY_BOOT |=> restart_out) else $error("no restart");
    chk_marker_keep: assert property (
        req_in.wr && req_in.index == IDX_VERIFY && req_in.sub == SUB_VER_DATE
        ##1 req_in.rd && !req_in.wr && req_in.index == IDX_VERIFY && req_in.sub == SUB_VER_DATE
        |=> rdata_out == $past(req_in.wdata, 2)) else $error("marker not kept");
    chk_marker_clear: assert property (
        req_in.wr && req_in.savable && req_in.index != IDX_STORE && req_in.index != IDX_VERIFY
        ##1 req_in.rd && !req_in.wr && req_in.index == IDX_VERIFY
        |=> rdata_out == 32'h00000000) else $error("marker not cleared");
    chk_reload_boot: assert property ($fell(sys_rst_in) |-> ##[0:2] nv_reload_out)
        else $error("no reload after reset");
    chk_prog_auto: assert property (
        $fell(sys_rst_in) && prog_loaded_in |-> ##[0:2] prog_start_out)
        else $error("no autostart");
endmodule

// ===== testbench/psr_nv_model.sv
// Purpose: storage engine stand-in that acknowledges jobs
// Assumes: start is a one-cycle pulse
// Notes: slow mode stretches the job to exercise polling
`timescale 1ns/1ps
module psr_nv_model
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic slow_in,
    output logic nv_done_out
);
    logic [4:0] cnt_reg;
    always_ff @(posedge sys_clk_in)
    begin
        nv_done_out <= 1'b0;
        if (sys_rst_in)
            cnt_reg <= 5'h00;
        else if (start_in)
            cnt_reg <= slow_in ? 5'h14 : 5'h06;
        else if (cnt_reg != 5'h00)
        begin
            cnt_reg <= cnt_reg - 5'h01;
            nv_done_out <= (cnt_reg == 5'h01);
        end
    end
endmodule

// ===== testbench/psr_store_restore_tb.sv
// Purpose: self-checking bench for the store/restore command block
// Assumes: inputs change at the falling edge
// Notes: subindex 00 used for the user program control word
`timescale 1ns/1ps
module psr_store_restore_tb
    import psr_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    psr_req_t req = '0;
    logic loaded = 1'b1;
    logic slow = 1'b0;
    logic nv_done, rvalid, nv_save, nv_disc, reload, restart, pstart, busy;
    logic [31:0] rdata;
    logic [6:0] cats;
    int bad_count = 0;
    int checked = 0;
    int i;
    logic [7:0] subs [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0B};
    logic [5:0] scat [7] = '{6'h3F, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
    psr_store_restore psr_store_restore_i (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst),
        .req_in(req), .nv_done_in(nv_done), .prog_loaded_in(loaded), .rdata_out(rdata),
        .rvalid_out(rvalid), .nv_save_out(nv_save), .nv_discard_out(nv_disc),
        .nv_cats_out(cats), .nv_reload_out(reload), .restart_out(restart),
        .prog_start_out(pstart), .busy_out(busy));
    psr_nv_model psr_nv_model_i (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst),
        .start_in(nv_save | nv_disc), .slow_in(slow), .nv_done_out(nv_done));
    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] d,
        input logic sv);
        req = '{1'b1, 1'b0, idx, sb, d, sv};
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] exp);
        req = '{1'b0, 1'b1, idx, sb, 32'h00000000, 1'b0};
        @(negedge sys_clk);
        // read data stands one cycle only; the next call replaces the strobe
        chk(rvalid, 1, "rvalid");
        chk(rdata, exp, "rdata");
    endtask
    task automatic wait_idle();
        int n;
        req = '0;
        for (n = 0; n < 100 && busy !== 1'b0; n++)
            @(negedge sys_clk);
        chk(busy, 0, "busy end");
    endtask
    task automatic do_reset(input logic ld);
        int n;
        int rl;
        int ps;
        rl = 0;
        ps = 0;
        loaded = ld;
        sys_rst = 1'b1;
        req = '0;
        repeat (12) @(negedge sys_clk);
        sys_rst = 1'b0;
        for (n = 0; n < 4; n++)
        begin
            @(negedge sys_clk);
            rl += int'(reload === 1'b1);
            ps += int'(pstart === 1'b1);
        end
        chk(rl, 1, "reload pulses");
        chk(ps, ld, "autostart pulses");
    endtask
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #2000000;
        bad_count++;
        $display("CHECK FAILED at %0t: timeout", $time);
        finish_test();
    end
    initial
    begin
        do_reset(1'b1);
        rd(IDX_USER_PROG, 8'h00, USER_PROG_RST_VAL);
        wr(IDX_USER_PROG, 8'h00, 32'h00000000, 1'b1);
        rd(IDX_USER_PROG, 8'h00, 32'h00000000);
        rd(IDX_STORE, 8'h07, 32'h00000000);
        $display("test reset done");
        for (i = 0; i < 7; i++)
        begin
            slow = i[0];
            wr(IDX_STORE, subs[i], KEY_SAVE, 1'b0);
            chk(nv_save, 1, "save pulse");
            chk(cats[5:0], scat[i], "save cats");
            rd(IDX_STORE, subs[i], KEY_SAVE);
            wr(IDX_DISCARD, SUB_COMM, KEY_LOAD, 1'b0);
            chk(nv_disc, 0, "discard while busy");
            wait_idle();
            rd(IDX_STORE, subs[i], STORE_DONE_VAL);
        end
        $display("test save done");
        for (i = 0; i < 7; i++)
        begin
            wr(IDX_DISCARD, subs[i], KEY_LOAD, 1'b0);
            chk(nv_disc, 1, "discard pulse");
            chk(nv_save, 0, "no save on discard");
            chk(cats[5:0], (i == 0) ? 6'h2F : scat[i], "discard cats");
            wait_idle();
        end
        wr(IDX_STORE, SUB_APP, KEY_LOAD, 1'b0);
        chk(nv_save, 0, "wrong key save");
        wr(IDX_DISCARD, SUB_APP, KEY_SAVE, 1'b0);
        chk(nv_disc, 0, "wrong key discard");
        $display("test discard done");
        wr(IDX_VERIFY, SUB_VER_DATE, 32'h0A0B0C0D, 1'b0);
        rd(IDX_VERIFY, SUB_VER_DATE, 32'h0A0B0C0D);
        wr(IDX_VERIFY, SUB_VER_TIME, 32'h00112233, 1'b0);
        wr(IDX_STORE, SUB_ALL, KEY_SAVE, 1'b0);
        wait_idle();
        rd(IDX_VERIFY, SUB_VER_TIME, 32'h00112233);
        wr(16'h6081, 8'h00, 32'h00000005, 1'b1);
        rd(IDX_VERIFY, SUB_VER_DATE, VERIFY_RST_VAL);
        rd(IDX_VERIFY, SUB_VER_TIME, VERIFY_RST_VAL);
        $display("test marker done");
        wr(IDX_REBOOT, SUB_BOOT, KEY_BOOT, 1'b0);
        chk(restart, 1, "restart");
        wr(IDX_REBOOT, SUB_BOOT, KEY_SAVE, 1'b0);
        chk(restart, 0, "no restart");
        do_reset(1'b0);
        rd(IDX_VERIFY, SUB_VER_DATE, VERIFY_RST_VAL);
        rd(IDX_VERIFY, SUB_VER_TIME, VERIFY_RST_VAL);
        $display("test restart done");
        finish_test();
    end
endmodule
bind psr_store_restore psr_store_restore_sva psr_store_restore_sva_i (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .req_in(req_in),
    .nv_done_in(nv_done_in), .prog_loaded_in(prog_loaded_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .nv_save_out(nv_save_out), .nv_discard_out(nv_discard_out),
    .nv_cats_out(nv_cats_out), .nv_reload_out(nv_reload_out), .restart_out(restart_out),
    .prog_start_out(prog_start_out), .busy_out(busy_out));
